// ===== src/vpl_regs.svh
// vpl link constants, command codes and packet codes
`ifndef VPL_REGS_SVH
`define VPL_REGS_SVH
`define VPL_HALF_LAST 4'h7
`define VPL_WAKE      16'h0100
`define VPL_WAKE2     16'h0200
`define VPL_LP_MIN    8'h10
`define VPL_OVH       8'h02
`define VPL_V_LAST    10'h27a
`define VPL_HSW       8'h46
`define VPL_VSW       8'h02
`define VPL_REV_MAX   4'h4
`define VPL_TURN_CLKS 16'h002c
`define VPL_REV_EN    1'h1
`define VPL_MD_PULSE  2'h0
`define VPL_CMD_LINE  3'h0
`define VPL_CMD_SEND  3'h1
`define VPL_CMD_BLANK 3'h2
`define VPL_CMD_PIXEL 3'h3
`define VPL_CMD_LP    3'h4
`define VPL_CMD_BTA   3'h5
`define VPL_CMD_NVID  3'h6
`define VPL_PK_VSS    8'h01
`define VPL_PK_VSE    8'h11
`define VPL_PK_HSS    8'h21
`define VPL_PK_HSE    8'h31
`define VPL_PK_BLK    8'h19
`define VPL_PK_PIX    8'h3e
`define VPL_PK_NVD    8'h29
`endif

// ===== src/vpl_pkg.sv
// vpl shared state types
`default_nettype none
package vpl_pkg;
	typedef enum logic [2:0] {H_WAKE, H_IDLE, H_LPW, H_HDR, H_LEN, H_PAY, H_TURN} vpl_hst_t;
	typedef enum logic [1:0] {D_HDR, D_LEN, D_PAY} vpl_dst_t;
endpackage : vpl_pkg
`default_nettype wire

// ===== src/vpl_if.sv
// vpl link wires between host and display ends
`default_nettype none
interface vpl_if;
	logic       lclk;
	logic       hs_act;
	logic [7:0] hs_dat;
	logic       turn;
	logic       pnl_rst_b;
	logic       lp0_h_o;
	logic       lp0_h_oe;
	logic       lp0_d_o;
	logic       lp0_d_oe;
	logic       lp0;
	// undriven lane0 rests in stop state
	assign lp0 = lp0_h_oe ? lp0_h_o : (lp0_d_oe ? lp0_d_o : 1'h1);
	modport host (output lclk, hs_act, hs_dat, turn, pnl_rst_b, lp0_h_o, lp0_h_oe,
		input lp0);
	modport dev (input lclk, hs_act, hs_dat, turn, pnl_rst_b, output lp0_d_o, lp0_d_oe);
endinterface : vpl_if
`default_nettype wire

// ===== src/vpl_sync.sv
// vpl two-flop synchroniser, one per bit
`default_nettype none
module vpl_sync #(
	parameter int W = 1
) (
	input  wire logic         SYS_CLK,
	input  wire logic         RST_B,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);
	logic [W-1:0] m_q;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge SYS_CLK or negedge RST_B) begin
				if (!RST_B) begin
					m_q[i] <= 1'h0;
					Q[i]   <= 1'h0;
				end else begin
					m_q[i] <= D[i];
					Q[i]   <= m_q[i];
				end
			end
		end
	endgenerate
endmodule // vpl_sync
`default_nettype wire

// ===== src/vpl_dev.sv
// vpl display end: packet parser, sync regeneration, reverse sender
`include "vpl_regs.svh"
`default_nettype none
module vpl_dev (
	input  wire logic       SYS_CLK,
	input  wire logic       RST_B,
	vpl_if.dev              LNK,
	input  wire logic [1:0] MODE,
	output logic            VSYNC,
	output logic            HSYNC,
	output logic            PIX_VLD,
	output logic            NV_VLD,
	output logic      [7:0] RX_DAT,
	input  wire logic       REV_VLD,
	input  wire logic [7:0] REV_DAT,
	output logic            REV_TAKE
);
	// ==========================================
	// link sampling
	logic [11:0]         in_s;
	logic                lclk_p_q;
	vpl_pkg::vpl_dst_t   st_q, st_d;
	logic [7:0]          typ_q, left_q, hcnt_q, vcnt_q;
	logic [3:0]          bud_q, rb_q;
	logic [7:0]          sh_q;
	logic                turn_p_q, oe_q, o_q;
	wire                 lclk_s = in_s[11];
	wire                 hs_s   = in_s[10];
	wire                 turn_s = in_s[9];
	wire                 up_s   = in_s[8];
	wire [7:0]           dat_s  = in_s[7:0];

	vpl_sync #(.W(12)) u_in (
		.SYS_CLK (SYS_CLK),
		.RST_B   (RST_B),
		.D       ({LNK.lclk, LNK.hs_act, LNK.turn, LNK.pnl_rst_b, LNK.hs_dat}),
		.Q       (in_s)
	);

	wire rise_w = lclk_s & ~lclk_p_q & up_s;
	wire fall_w = ~lclk_s & lclk_p_q & up_s;
	wire got_w  = rise_w & hs_s;
	wire hdr_w  = got_w & (st_q == vpl_pkg::D_HDR);
	wire vss_w  = hdr_w & (dat_s == `VPL_PK_VSS);
	wire hss_w  = hdr_w & (dat_s == `VPL_PK_HSS);
	wire vse_w  = hdr_w & (dat_s == `VPL_PK_VSE);
	wire hse_w  = hdr_w & (dat_s == `VPL_PK_HSE);
	wire known_w = vss_w | hss_w | vse_w | hse_w | (dat_s == `VPL_PK_BLK)
		| (dat_s == `VPL_PK_PIX) | (dat_s == `VPL_PK_NVD);
	wire evt_w  = MODE != `VPL_MD_PULSE;
	wire pay_w  = got_w & (st_q == vpl_pkg::D_PAY);

	// ==========================================
	// packet parser
	// any order accepted
	always_comb begin
		st_d = st_q;
		if (!hs_s) begin
			st_d = vpl_pkg::D_HDR;
		end else if (got_w) begin
			unique case (st_q)
				vpl_pkg::D_HDR: if (known_w) st_d = vpl_pkg::D_LEN;
				vpl_pkg::D_LEN: st_d = (dat_s == 8'h00) ? vpl_pkg::D_HDR : vpl_pkg::D_PAY;
				vpl_pkg::D_PAY: if (left_q == 8'h01) st_d = vpl_pkg::D_HDR;
				default: st_d = vpl_pkg::D_HDR;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q     <= vpl_pkg::D_HDR;
			lclk_p_q <= 1'h0;
			typ_q    <= 8'h00;
			left_q   <= 8'h00;
		end else begin
			st_q     <= st_d;
			lclk_p_q <= lclk_s;
			if (hdr_w) typ_q <= dat_s;
			if (got_w) left_q <= (st_q == vpl_pkg::D_LEN) ? dat_s : left_q - 8'h01;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PIX_VLD <= 1'h0;
			NV_VLD  <= 1'h0;
			RX_DAT  <= 8'h00;
		end else begin
			PIX_VLD <= pay_w & (typ_q == `VPL_PK_PIX);
			NV_VLD  <= pay_w & (typ_q == `VPL_PK_NVD);
			if (got_w) RX_DAT <= dat_s;
		end
	end

	// ==========================================
	// sync rebuild
	// events rebuild widths
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			HSYNC  <= 1'h0;
			hcnt_q <= 8'h00;
		end else if (hss_w) begin
			HSYNC  <= 1'h1;
			hcnt_q <= `VPL_HSW;
		end else if (hse_w & ~evt_w) begin
			HSYNC <= 1'h0;
		end else if (evt_w & rise_w & HSYNC) begin
			if (hcnt_q == 8'h01) HSYNC <= 1'h0;
			hcnt_q <= hcnt_q - 8'h01;
		end
	end

	// vertical width counted in lines, so by line starts
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			VSYNC  <= 1'h0;
			vcnt_q <= 8'h00;
		end else if (vss_w) begin
			VSYNC  <= 1'h1;
			vcnt_q <= `VPL_VSW;
		end else if (vse_w & ~evt_w) begin
			VSYNC <= 1'h0;
		end else if (evt_w & hss_w & VSYNC) begin
			if (vcnt_q == 8'h01) VSYNC <= 1'h0;
			vcnt_q <= vcnt_q - 8'h01;
		end
	end

	// ==========================================
	// reverse sender
	// LP after turnaround
	wire may_w = turn_s & ~hs_s & `VPL_REV_EN;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			turn_p_q <= 1'h0;
			bud_q    <= 4'h0;
		end else begin
			turn_p_q <= turn_s;
			if (turn_s & ~turn_p_q) bud_q <= `VPL_REV_MAX;
			else if (REV_TAKE) bud_q <= bud_q - 4'h1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			oe_q     <= 1'h0;
			o_q      <= 1'h1;
			rb_q     <= 4'h0;
			sh_q     <= 8'h00;
			REV_TAKE <= 1'h0;
		end else begin
			REV_TAKE <= 1'h0;
			if (fall_w) begin
				if (!may_w) begin
					oe_q <= 1'h0;
					o_q  <= 1'h1;
					rb_q <= 4'h0;
				end else if (rb_q != 4'h0) begin
					rb_q <= (rb_q == 4'h9) ? 4'h0 : rb_q + 4'h1;
					o_q  <= (rb_q == 4'h9) ? 1'h1 : sh_q[7];
					sh_q <= {sh_q[6:0], 1'h0};
				end else if (REV_VLD && bud_q != 4'h0 && !REV_TAKE) begin
					oe_q     <= 1'h1;
					o_q      <= 1'h0;
					sh_q     <= REV_DAT;
					rb_q     <= 4'h1;
					REV_TAKE <= 1'h1;
				end else begin
					// release early so the host retakes lane0 cleanly
					oe_q <= 1'h0;
					o_q  <= 1'h1;
				end
			end
		end
	end

	assign LNK.lp0_d_o  = o_q;
	assign LNK.lp0_d_oe = oe_q;
endmodule // vpl_dev
`default_nettype wire

// ===== src/vpl_host.sv
// vpl host end: clock lane, packet sender, turnaround receiver
`include "vpl_regs.svh"
`default_nettype none
module vpl_host (
	input  wire logic       SYS_CLK,
	input  wire logic       RST_B,
	vpl_if.host             LNK,
	input  wire logic [1:0] MODE,
	input  wire logic       CMD_VLD,
	input  wire logic [2:0] CMD_TYPE,
	input  wire logic [7:0] CMD_LEN,
	output logic            CMD_RDY,
	input  wire logic [7:0] BYTE_DAT,
	output logic            BYTE_TAKE,
	output logic            REV_VLD,
	output logic      [7:0] REV_DAT
);
	// ==========================================
	// state
	vpl_pkg::vpl_hst_t st_q, st_d;
	logic [3:0]        div_q;
	logic              lclk_q;
	logic              run_q;
	logic [15:0]       cnt_q;
	logic [7:0]        hdr_q;
	logic [7:0]        pay_q;
	logic              fill_q;
	logic              pix_q;
	logic              go_hdr_q;
	logic [9:0]        line_q;
	logic              vs_q;
	logic              hs_q;
	logic [7:0]        dat_q;
	logic              turn_q;
	logic              prst_q;
	logic              lpoe_q;
	logic [3:0]        rbit_q;
	logic              lp0_s;

	// ==========================================
	// clock lane divider
	wire edge_w = run_q & (div_q == `VPL_HALF_LAST);
	wire fall_w = edge_w & lclk_q;
	wire rise_w = edge_w & ~lclk_q;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_q  <= 4'h0;
			lclk_q <= 1'h0;
		end else if (run_q) begin
			div_q <= edge_w ? 4'h0 : div_q + 4'h1;
			if (edge_w) lclk_q <= ~lclk_q;
		end
	end

	// ==========================================
	// command decode
	wire c_line  = CMD_TYPE == `VPL_CMD_LINE;
	wire c_send  = CMD_TYPE == `VPL_CMD_SEND;
	wire c_blk   = CMD_TYPE == `VPL_CMD_BLANK;
	wire c_pix   = CMD_TYPE == `VPL_CMD_PIXEL;
	wire c_lp    = CMD_TYPE == `VPL_CMD_LP;
	wire c_bta   = CMD_TYPE == `VPL_CMD_BTA;
	wire c_nv    = CMD_TYPE == `VPL_CMD_NVID;
	wire take_w  = CMD_VLD & CMD_RDY;
	wire frm_w   = line_q == 10'h000;
	wire evt_w   = MODE != `VPL_MD_PULSE;
	wire lp_ok_w = c_lp & (CMD_LEN >= `VPL_LP_MIN);
	wire blk_ok_w = CMD_LEN > `VPL_OVH;
	wire [7:0] blk_len_w = CMD_LEN - `VPL_OVH;
	wire pre_w   = c_line & frm_w;
	wire send_ok_w = c_send & ~evt_w;
	wire snd_w = c_line | send_ok_w | (c_pix & (CMD_LEN != 8'h00))
		| ((c_blk | c_nv | (c_lp & ~lp_ok_w)) & blk_ok_w);
	wire [7:0] sync_w = frm_w ? `VPL_PK_VSS : `VPL_PK_HSS;
	wire [7:0] end_w  = vs_q ? `VPL_PK_VSE : `VPL_PK_HSE;
	wire [7:0] hdr_w  = c_line ? sync_w : c_send ? end_w : c_pix ? `VPL_PK_PIX
		: c_nv ? `VPL_PK_NVD : `VPL_PK_BLK;
	wire [7:0] pay_w  = c_pix ? CMD_LEN : (c_line | c_send) ? 8'h00 : blk_len_w;
	wire [15:0] load_w = lp_ok_w ? {8'h00, CMD_LEN}
		: pre_w ? {8'h00, `VPL_LP_MIN} : `VPL_TURN_CLKS;
	wire last_w = (st_q == vpl_pkg::H_PAY) & (cnt_q == 16'h0001);

	// ==========================================
	// sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			vpl_pkg::H_WAKE: begin
				if (cnt_q == `VPL_WAKE2) st_d = vpl_pkg::H_IDLE;
			end
			vpl_pkg::H_IDLE: begin
				if (take_w) begin
					if (pre_w | lp_ok_w) st_d = vpl_pkg::H_LPW;
					else if (snd_w) st_d = vpl_pkg::H_HDR;
					else if (c_bta) st_d = vpl_pkg::H_TURN;
				end
			end
			vpl_pkg::H_LPW: begin
				if (fall_w && cnt_q == 16'h0000) begin
					st_d = go_hdr_q ? vpl_pkg::H_HDR : vpl_pkg::H_IDLE;
				end
			end
			vpl_pkg::H_HDR: begin
				if (fall_w) st_d = vpl_pkg::H_LEN;
			end
			vpl_pkg::H_LEN: begin
				if (fall_w) st_d = (pay_q == 8'h00) ? vpl_pkg::H_IDLE : vpl_pkg::H_PAY;
			end
			vpl_pkg::H_PAY: begin
				if (fall_w && last_w) st_d = pix_q ? vpl_pkg::H_LPW : vpl_pkg::H_IDLE;
			end
			vpl_pkg::H_TURN: begin
				if (fall_w && cnt_q == 16'h0000) st_d = vpl_pkg::H_IDLE;
			end
			default: st_d = vpl_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q    <= vpl_pkg::H_WAKE;
			run_q   <= 1'h0;
			prst_q  <= 1'h0;
			CMD_RDY <= 1'h0;
		end else begin
			st_q    <= st_d;
			CMD_RDY <= st_d == vpl_pkg::H_IDLE;
			if (st_q == vpl_pkg::H_WAKE && cnt_q == `VPL_WAKE) prst_q <= 1'h1;
			if (st_q == vpl_pkg::H_WAKE && cnt_q == `VPL_WAKE2) run_q <= 1'h1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt_q <= 16'h0000;
		end else if (st_q == vpl_pkg::H_WAKE) begin
			cnt_q <= cnt_q + 16'h0001;
		end else if (take_w) begin
			cnt_q <= load_w;
		end else if (fall_w) begin
			if (st_q == vpl_pkg::H_LEN) cnt_q <= {8'h00, pay_q};
			else if (last_w && pix_q) cnt_q <= {8'h00, `VPL_LP_MIN};
			else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			hdr_q    <= 8'h00;
			pay_q    <= 8'h00;
			fill_q   <= 1'h0;
			pix_q    <= 1'h0;
			go_hdr_q <= 1'h0;
		end else if (take_w) begin
			hdr_q    <= hdr_w;
			pay_q    <= pay_w;
			fill_q   <= c_blk | c_lp;
			pix_q    <= c_pix;
			go_hdr_q <= pre_w;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			line_q <= 10'h000;
			vs_q   <= 1'h0;
		end else if (take_w && c_line) begin
			line_q <= (line_q == `VPL_V_LAST) ? 10'h000 : line_q + 10'h001;
			vs_q   <= frm_w;
		end
	end

	// ==========================================
	// data lanes
	wire in_pkt_w = (st_q == vpl_pkg::H_HDR) | (st_q == vpl_pkg::H_LEN)
		| (st_q == vpl_pkg::H_PAY);
	wire hs_d = in_pkt_w | ((st_q == vpl_pkg::H_IDLE) & hs_q);
	wire [7:0] dat_d = (st_q == vpl_pkg::H_HDR) ? hdr_q
		: (st_q == vpl_pkg::H_LEN) ? pay_q
		: (st_q == vpl_pkg::H_PAY && !fill_q) ? BYTE_DAT : 8'h00;

	// lanes change on the falling edge so the display samples mid-bit
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			hs_q      <= 1'h0;
			dat_q     <= 8'h00;
			BYTE_TAKE <= 1'h0;
		end else begin
			BYTE_TAKE <= fall_w & (st_q == vpl_pkg::H_PAY) & ~fill_q;
			if (fall_w) begin
				hs_q  <= hs_d;
				dat_q <= dat_d;
			end
		end
	end

	// ==========================================
	// turnaround and reverse receive
	wire own_w = (st_q == vpl_pkg::H_TURN) & (cnt_q != 16'h0000);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			turn_q <= 1'h0;
			lpoe_q <= 1'h1;
		end else if (fall_w) begin
			turn_q <= own_w;
			lpoe_q <= ~own_w;
		end
	end

	vpl_sync #(.W(1)) u_lp0 (
		.SYS_CLK (SYS_CLK),
		.RST_B   (RST_B),
		.D       (LNK.lp0),
		.Q       (lp0_s)
	);

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rbit_q  <= 4'h0;
			REV_DAT <= 8'h00;
			REV_VLD <= 1'h0;
		end else begin
			REV_VLD <= rise_w & turn_q & (rbit_q == 4'h8);
			if (!turn_q) begin
				rbit_q <= 4'h0;
			end else if (rise_w) begin
				if (rbit_q != 4'h0) begin
					REV_DAT <= {REV_DAT[6:0], lp0_s};
					rbit_q  <= (rbit_q == 4'h8) ? 4'h0 : rbit_q + 4'h1;
				end else if (!lp0_s) begin
					rbit_q <= 4'h1;
				end
			end
		end
	end

	// ==========================================
	// link outputs
	assign LNK.lclk      = lclk_q;
	assign LNK.hs_act    = hs_q;
	assign LNK.hs_dat    = dat_q;
	assign LNK.turn      = turn_q;
	assign LNK.pnl_rst_b = prst_q;
	// driving means stop-state high, so output equals enable
	assign LNK.lp0_h_o   = lpoe_q;
	assign LNK.lp0_h_oe  = lpoe_q;
endmodule // vpl_host
`default_nettype wire

// ===== verif/vpl_sva.sv
// vpl link checker watching the joined lanes
`default_nettype none
module vpl_sva (
	input wire logic       SYS_CLK,
	input wire logic       RST_B,
	input wire logic       lclk,
	input wire logic       hs_act,
	input wire logic [7:0] hs_dat,
	input wire logic       turn,
	input wire logic       pnl_rst_b,
	input wire logic       lp0_h_o,
	input wire logic       lp0_h_oe,
	input wire logic       lp0_d_o,
	input wire logic       lp0_d_oe,
	input wire logic       lp0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] run_q;
	logic       prev_q;
	logic       started_q;
	// ==========================================
	// link clock half period tracking
	// wraps before start, so only trusted once started
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			run_q     <= 4'h0;
			prev_q    <= 1'h0;
			started_q <= 1'h0;
		end else begin
			run_q     <= (lclk != prev_q) ? 4'h0 : run_q + 4'h1;
			prev_q    <= lclk;
			started_q <= started_q | lclk;
		end
	end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);
	// ==========================================
	// assertions
	AST_WAKE_STOP: assert property (
		!pnl_rst_b |-> lp0_h_oe && lp0_h_o && lp0 && !hs_act && !lclk)
		else $error("lanes left stop state before display wake");
	AST_CLK_RUN: assert property (started_q |-> run_q < 4'h8)
		else $error("link clock stalled");
	AST_CLK_HALF: assert property (started_q && $changed(lclk) |-> run_q == 4'h7)
		else $error("link clock half period not 8 cycles");
	AST_HS_CLK: assert property (hs_act |-> started_q)
		else $error("high speed lanes without running clock");
	// lanes and link clock leave the host on the same system edge
	AST_LANE_EDGE: assert property (
		$changed({hs_act, hs_dat}) |-> !lclk && $past(lclk))
		else $error("forward lanes changed off the clock fall");
	AST_HS_FWD: assert property (hs_act |-> !lp0_d_oe && !turn)
		else $error("display drove lane0 during high speed");
	AST_REV_OWN: assert property ($rose(lp0_d_oe) |-> turn && !lp0_h_oe)
		else $error("display drove lane0 without turnaround");
	AST_TURN_QUIET: assert property (turn |-> !hs_act && !lp0_h_oe)
		else $error("host active while display owns lane0");
	AST_TURN_BOUND: assert property ($rose(turn) |-> ##[1:720] !turn)
		else $error("reverse window not bounded");
	// four bytes of ten link bits each, sixteen cycles a bit
	AST_REV_BOUND: assert property ($rose(lp0_d_oe) |-> ##[1:660] !lp0_d_oe)
		else $error("display held lane0 past its byte budget");
	cover property ($rose(turn));
	cover property (turn && lp0_d_oe && !lp0_d_o);
	cover property ($fell(hs_act));
endmodule // vpl_sva
`default_nettype wire

// ===== verif/testbench.sv
// vpl bench: host and display joined, queue reference model
`include "vpl_regs.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic       sys_clk, rst_b, cmd_vld, cmd_rdy, byte_take, rev_vld, h_rev_vld;
	logic       vsync, hsync, pix_vld, nv_vld, rev_take;
	logic [1:0] mode;
	logic [2:0] cmd_type, typ;
	logic [7:0] cmd_len, byte_dat, rev_dat, h_rev_dat, rx_dat, len;
	logic [7:0] exp_pix[$], exp_nv[$], exp_rev[$], rev_src[$], wq[$];
	int         failures = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         hs_rises = 0;
	int         rev_got = 0;
	int         n0;
	vpl_if lnk ();
	vpl_host u_vpl_host (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .LNK(lnk), .MODE(mode), .CMD_VLD(cmd_vld),
		.CMD_TYPE(cmd_type), .CMD_LEN(cmd_len), .CMD_RDY(cmd_rdy), .BYTE_DAT(byte_dat),
		.BYTE_TAKE(byte_take), .REV_VLD(h_rev_vld), .REV_DAT(h_rev_dat)
	);
	vpl_dev u_vpl_dev (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .LNK(lnk), .MODE(mode), .VSYNC(vsync),
		.HSYNC(hsync), .PIX_VLD(pix_vld), .NV_VLD(nv_vld), .RX_DAT(rx_dat),
		.REV_VLD(rev_vld), .REV_DAT(rev_dat), .REV_TAKE(rev_take)
	);
	vpl_sva u_vpl_sva (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .lclk(lnk.lclk), .hs_act(lnk.hs_act),
		.hs_dat(lnk.hs_dat), .turn(lnk.turn), .pnl_rst_b(lnk.pnl_rst_b),
		.lp0_h_o(lnk.lp0_h_o), .lp0_h_oe(lnk.lp0_h_oe), .lp0_d_o(lnk.lp0_d_o),
		.lp0_d_oe(lnk.lp0_d_oe), .lp0(lnk.lp0)
	);
	// ==========================================
	// shared tasks
	function automatic logic [7:0] pop(ref logic [7:0] q[$]);
		return (q.size() > 0) ? q.pop_front() : 8'hxx;
	endfunction
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_byte(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic test_done();
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// waits for idle, then lets the display's synced view catch up
	task automatic settle();
		int n;
		repeat (2) @(negedge sys_clk);
		for (n = 0; n < 4000 && cmd_rdy !== 1'b1; n++) @(negedge sys_clk);
		if (n == 4000) failures++;
		repeat (40) @(negedge sys_clk);
	endtask
	task automatic send_cmd(input logic [2:0] t, input logic [7:0] l);
		int n;
		@(negedge sys_clk);
		cmd_type = t;
		cmd_len = l;
		cmd_vld = 1'b1;
		for (n = 0; n < 2000 && cmd_rdy !== 1'b1; n++) @(negedge sys_clk);
		if (n == 2000) failures++;
		@(negedge sys_clk);
		cmd_vld = 1'b0;
		settle();
	endtask
	// ==========================================
	// clock, watchdog, lane and reference monitors
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			test_done();
		end
	end
	always @(posedge lnk.lclk) if (lnk.hs_act === 1'b1) wq.push_back(lnk.hs_dat);
	always @(posedge lnk.hs_act) hs_rises++;
	always @(negedge sys_clk) begin
		if (byte_take === 1'b1) begin
			if (cmd_type == `VPL_CMD_PIXEL) exp_pix.push_back(byte_dat);
			else exp_nv.push_back(byte_dat);
			byte_dat = 8'($urandom);
		end
		if (rev_take === 1'b1) begin
			exp_rev.push_back(rev_dat);
			if (rev_src.size() > 0) rev_dat = rev_src.pop_front();
			else rev_vld = 1'b0;
		end
		if (pix_vld === 1'b1) chk_byte("pixel", pop(exp_pix), rx_dat);
		if (nv_vld === 1'b1) chk_byte("non-video byte", pop(exp_nv), rx_dat);
		if (h_rev_vld === 1'b1) begin
			rev_got++;
			chk_byte("reverse byte", pop(exp_rev), h_rev_dat);
		end
	end
	// ==========================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		mode = 2'h0;
		cmd_vld = 1'b0;
		cmd_type = 3'h0;
		cmd_len = 8'h00;
		rev_vld = 1'b0;
		rev_dat = 8'h00;
		byte_dat = 8'($urandom(90));
		repeat (2) @(negedge sys_clk);
		chk_bit("display reset", 1'b0, lnk.pnl_rst_b);
		chk_bit("lane0 stop", 1'b1, lnk.lp0);
		rst_b = 1'b1;
		settle();
		for (int k = 0; k < 2; k++) begin
			send_cmd(`VPL_CMD_LINE, 8'h00);
			chk_bit("sync start", 1'b1, k ? hsync : vsync);
			send_cmd(`VPL_CMD_SEND, 8'h00);
			chk_bit("sync end", 1'b0, k ? hsync : vsync);
		end
		for (int k = 0; k < 3; k++) begin
			typ = (k == 0) ? `VPL_CMD_BLANK : (k == 1) ? `VPL_CMD_PIXEL : `VPL_CMD_NVID;
			len = 8'($urandom_range(12, 3));
			wq.delete();
			send_cmd(typ, len);
			while (wq.size() > 0 && wq[0] == 8'h00) void'(wq.pop_front());
			chk_byte("header", (k == 0) ? `VPL_PK_BLK : (k == 1) ? `VPL_PK_PIX : `VPL_PK_NVD,
				pop(wq));
			chk_byte("length", (k == 1) ? len : len - `VPL_OVH, pop(wq));
			if (k == 1) chk_bit("low power after pixels", 1'b0, lnk.hs_act);
		end
		chk_bit("payload drained", 1'b1, exp_pix.size() + exp_nv.size() == 0);
		// zero periods and long low-power waits must start no burst
		n0 = hs_rises;
		send_cmd(`VPL_CMD_BLANK, `VPL_OVH);
		send_cmd(`VPL_CMD_PIXEL, 8'h00);
		send_cmd(`VPL_CMD_LP, 8'h14);
		chk_byte("bursts after omitted blanks", 8'(n0), 8'(hs_rises));
		mode = 2'h1;
		send_cmd(`VPL_CMD_SEND, 8'h00);
		chk_byte("bursts after dropped sync end", 8'(n0), 8'(hs_rises));
		send_cmd(`VPL_CMD_LINE, 8'h00);
		chk_bit("event sync start", 1'b1, hsync);
		repeat (1200) @(negedge sys_clk);
		chk_bit("regenerated sync end", 1'b0, hsync);
		mode = 2'h2;
		for (int k = 0; k < 4; k++) rev_src.push_back(8'($urandom));
		rev_dat = 8'($urandom);
		rev_vld = 1'b1;
		send_cmd(`VPL_CMD_PIXEL, 8'h06);
		send_cmd(`VPL_CMD_BTA, 8'h00);
		rev_vld = 1'b0;
		chk_byte("reverse count", 8'(`VPL_REV_MAX), 8'(rev_got));
		chk_bit("reverse delivered", 1'b1, exp_rev.size() == 0);
		test_done();
	end
endmodule // testbench
`default_nettype wire
